// ==== rtl/tfm_input_cell.sv ====
// One input terminal: polarity, edge detection and function decode.
// Assumes the pin is already synchronised to clock.
`timescale 1ns/1ps
module tfm_input_cell
  import tfm_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       pin_sync,
  input  wire logic       invert,
  input  wire logic [4:0] fsel,
  output logic            level_act,
  output logic            edge_act
);
  logic prev_reg;
  wire  active_lvl = pin_sync ^ invert;

  // ==========================================================
  // Remember the last active level to find the leading edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= active_lvl;
    end
  end

  // Level functions follow the level, others except FN_NONE fire once per leading edge
  assign level_act = active_lvl & tfm_is_level_fn(fsel);
  assign edge_act  = active_lvl & ~prev_reg & ~tfm_is_level_fn(fsel) &
                     (fsel != FN_NONE);
endmodule

// ==== rtl/tfm_mapper.sv ====
// Terminal function mapper top: registers, input mapping, output forcing.
// Assumes pins are asynchronous and the register master obeys strobe rules.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps

// Summary of operation
// - select 12 gives forward inching, 13 gives reverse inching.
// - select 14 makes the terminal the home sequence enable.
// - select 15 makes the terminal the position table enable.
// - selects 16 to 20 drive general input bits zero to four.
// - selects 4 and 5 drive motor enable and motor release.
// - functions 4,5,11,12,13 act on level; the rest except 0 on leading edges.
// - control word bits 0..2 drive output terminals 0..2.
// - active-level bit 1 inverts to falling edge or low level.
// - select 10 triggers motion in position mode.
module tfm_mapper
  import tfm_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rstn,
  input  wire logic [15:0]         reg_addr,
  input  wire logic [15:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [15:0]         reg_rdata,
  input  wire logic [NUM_IN-1:0]   input_terminal,
  output logic      [NUM_OUT-1:0]  output_terminal,
  output logic                     motor_enable,
  output logic                     motor_release,
  output logic                     inch_forward,
  output logic                     inch_reverse,
  output logic                     home_start,
  output logic                     position_table,
  output logic                     position_trigger,
  output logic      [NUM_GPIN-1:0] general_input
);

  // ==========================================================
  // Reset release
  logic rst_meta_reg;
  logic rst_n;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // ==========================================================
  // Register file
  logic [4:0]         fsel_reg [NUM_IN];
  logic [15:0]        out_ctrl_reg;
  logic [15:0]        act_level_reg;
  logic [15:0]        out0_fsel_reg;
  logic [NUM_IN-1:0]  pin_sync;

  // Codes above twenty are refused so only one legal function is held
  wire        wdata_legal = (reg_wdata <= {11'h000, FSEL_MAX});
  wire        wr_fsel_any = reg_wr && wdata_legal &&
                            (reg_addr >= ADDR_IN1_FSEL) && (reg_addr <= ADDR_IN4_FSEL);
  wire [1:0]  wr_fsel_idx = reg_addr[1:0];
  wire        wr_out_ctrl = reg_wr && (reg_addr == ADDR_OUT_CTRL);
  wire        wr_act_lvl  = reg_wr && (reg_addr == ADDR_ACT_LEVEL);
  wire        wr_out0_fs  = reg_wr && (reg_addr == ADDR_OUT0_FSEL);

  // Function selects; write stores the low five bits after range check
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_IN; i++) begin
        fsel_reg[i] <= FSEL_RESET[4:0];
      end
    end else if (wr_fsel_any) begin
      fsel_reg[wr_fsel_idx] <= reg_wdata[4:0];
    end
  end

  // Control, level and output select words
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_ctrl_reg  <= WORD_ZERO;
      act_level_reg <= WORD_ZERO;
      out0_fsel_reg <= FSEL_RESET;
    end else begin
      if (wr_out_ctrl) out_ctrl_reg  <= reg_wdata;
      if (wr_act_lvl)  act_level_reg <= reg_wdata;
      if (wr_out0_fs)  out0_fsel_reg <= reg_wdata;
    end
  end

  // Read mux; unmapped addresses answer zero
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = WORD_ZERO;
    case (reg_addr)
      ADDR_IN1_FSEL:  rd_mux = {11'h000, fsel_reg[0]};
      ADDR_IN2_FSEL:  rd_mux = {11'h000, fsel_reg[1]};
      ADDR_IN3_FSEL:  rd_mux = {11'h000, fsel_reg[2]};
      ADDR_IN4_FSEL:  rd_mux = {11'h000, fsel_reg[3]};
      ADDR_OUT_CTRL:  rd_mux = out_ctrl_reg;
      ADDR_ACT_LEVEL: rd_mux = act_level_reg;
      ADDR_OUT0_FSEL: rd_mux = out0_fsel_reg;
      ADDR_STATUS:    rd_mux = {12'h000, pin_sync};
      default:        rd_mux = WORD_ZERO;
    endcase
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= WORD_ZERO;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : WORD_ZERO;
    end
  end

  // ==========================================================
  // Input terminals
  tfm_sync2 #(.W(NUM_IN)) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .din   (input_terminal),
    .dout  (pin_sync)
  );

  logic [NUM_IN-1:0] lvl_act;
  logic [NUM_IN-1:0] edg_act;

  // Each cell applies its own polarity bit
  for (genvar g = 0; g < NUM_IN; g++) begin : g_cell
    tfm_input_cell u_cell (
      .clock     (clock),
      .rst_n     (rst_n),
      .pin_sync  (pin_sync[g]),
      .invert    (act_level_reg[g]),
      .fsel      (fsel_reg[g]),
      .level_act (lvl_act[g]),
      .edge_act  (edg_act[g])
    );
  end

  // Gather per-function requests over all terminals
  logic                motor_en_next;
  logic                motor_rel_next;
  logic                inch_fwd_next;
  logic                inch_rev_next;
  logic                home_next;
  logic                ptab_next;
  logic                ptrig_next;
  logic [NUM_GPIN-1:0] gpin_next;
  always_comb begin
    motor_en_next  = 1'b0;
    motor_rel_next = 1'b0;
    inch_fwd_next  = 1'b0;
    inch_rev_next  = 1'b0;
    home_next      = 1'b0;
    ptab_next      = 1'b0;
    ptrig_next     = 1'b0;
    gpin_next      = '0;
    for (int i = 0; i < NUM_IN; i++) begin
      motor_en_next  |= lvl_act[i] && (fsel_reg[i] == FN_MOTOR_ENABLE);
      motor_rel_next |= lvl_act[i] && (fsel_reg[i] == FN_MOTOR_RELEASE);
      inch_fwd_next  |= lvl_act[i] && (fsel_reg[i] == FN_INCH_FORWARD);
      inch_rev_next  |= lvl_act[i] && (fsel_reg[i] == FN_INCH_REVERSE);
      home_next      |= edg_act[i] && (fsel_reg[i] == FN_HOME_ENABLE);
      ptab_next      |= edg_act[i] && (fsel_reg[i] == FN_POSITION_TABLE);
      ptrig_next     |= edg_act[i] && (fsel_reg[i] == FN_POS_TRIGGER);
      for (int b = 0; b < NUM_GPIN; b++) begin
        gpin_next[b] |= edg_act[i] &&
                        (fsel_reg[i] == FN_GPIN_FIRST + 5'(b));
      end
    end
  end

  // ==========================================================
  // Registered outputs; edge functions give one-cycle pulses
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      motor_enable     <= 1'b0;
      motor_release    <= 1'b0;
      inch_forward     <= 1'b0;
      inch_reverse     <= 1'b0;
      home_start       <= 1'b0;
      position_table   <= 1'b0;
      position_trigger <= 1'b0;
      general_input    <= '0;
      output_terminal  <= '0;
    end else begin
      motor_enable     <= motor_en_next;
      motor_release    <= motor_rel_next;
      inch_forward     <= inch_fwd_next;
      inch_reverse     <= inch_rev_next;
      home_start       <= home_next;
      position_table   <= ptab_next;
      position_trigger <= ptrig_next;
      general_input    <= gpin_next;
      output_terminal  <= out_ctrl_reg[NUM_OUT-1:0];
    end
  end

  // ==========================================================
  // Checks
  property p_out_follows_ctrl;
    @(posedge clock) disable iff (!rst_n)
      wr_out_ctrl |=> ##1 (output_terminal == $past(reg_wdata[NUM_OUT-1:0], 2));
  endproperty
  a_out_follows_ctrl: assert property (p_out_follows_ctrl)
    else $error("output terminals do not follow control word");

  property p_illegal_refused;
    @(posedge clock) disable iff (!rst_n)
      (reg_wr && reg_addr == ADDR_IN1_FSEL && !wdata_legal) |=>
        $stable(fsel_reg[0]);
  endproperty
  a_illegal_refused: assert property (p_illegal_refused)
    else $error("out of range function code stored");

  property p_inch_fwd_level;
    @(posedge clock) disable iff (!rst_n)
      (pin_sync[0] != act_level_reg[0] && fsel_reg[0] == FN_INCH_FORWARD) |=>
        inch_forward;
  endproperty
  a_inch_fwd_level: assert property (p_inch_fwd_level)
    else $error("forward inching not held for active level");

  property p_inch_rev_level;
    @(posedge clock) disable iff (!rst_n)
      (pin_sync[1] != act_level_reg[1] && fsel_reg[1] == FN_INCH_REVERSE) |=>
        inch_reverse;
  endproperty
  a_inch_rev_level: assert property (p_inch_rev_level)
    else $error("reverse inching not held for active level");

  // Decode checks: home enable, position table and general input bits zero and four each reach their own output
  property p_home_map;
    @(posedge clock) disable iff (!rst_n)
      (edg_act[2] && fsel_reg[2] == FN_HOME_ENABLE) |=> home_start;
  endproperty
  a_home_map: assert property (p_home_map)
    else $error("home enable edge not passed on");

  property p_ptab_map;
    @(posedge clock) disable iff (!rst_n)
      (edg_act[3] && fsel_reg[3] == FN_POSITION_TABLE) |=> position_table;
  endproperty
  a_ptab_map: assert property (p_ptab_map)
    else $error("position table edge not passed on");

  property p_gpin_zero;
    @(posedge clock) disable iff (!rst_n)
      (fsel_reg[0] == FN_GPIN_FIRST && edg_act[0]) |=> general_input[0];
  endproperty
  a_gpin_zero: assert property (p_gpin_zero)
    else $error("general input bit zero missed");

  property p_gpin_four;
    @(posedge clock) disable iff (!rst_n)
      (fsel_reg[0] == FN_GPIN_LAST && edg_act[0]) |=> general_input[NUM_GPIN-1];
  endproperty
  a_gpin_four: assert property (p_gpin_four)
    else $error("general input bit four missed");

  // Level functions follow the terminal while it stays active
  property p_motor_en;
    @(posedge clock) disable iff (!rst_n)
      (lvl_act[0] && fsel_reg[0] == FN_MOTOR_ENABLE) |=> motor_enable;
  endproperty
  a_motor_en: assert property (p_motor_en)
    else $error("motor enable level not passed on");

  property p_motor_rel;
    @(posedge clock) disable iff (!rst_n)
      (lvl_act[1] && fsel_reg[1] == FN_MOTOR_RELEASE) |=> motor_release;
  endproperty
  a_motor_rel: assert property (p_motor_rel)
    else $error("motor release level not passed on");

  property p_edge_once;
    @(posedge clock) disable iff (!rst_n)
      edg_act[0] |=> !edg_act[0];
  endproperty
  a_edge_once: assert property (p_edge_once)
    else $error("edge function fired twice");

  property p_edge_rise;
    @(posedge clock) disable iff (!rst_n)
      edg_act[0] |-> (pin_sync[0] != act_level_reg[0]) &&
                     ($past(pin_sync[0]) == $past(act_level_reg[0]));
  endproperty
  a_edge_rise: assert property (p_edge_rise)
    else $error("edge function fired without a leading edge");

  property p_none_quiet;
    @(posedge clock) disable iff (!rst_n)
      (fsel_reg[0] == FN_NONE) |-> !lvl_act[0] && !edg_act[0];
  endproperty
  a_none_quiet: assert property (p_none_quiet)
    else $error("unassigned terminal produced a request");

  property p_level_off;
    @(posedge clock) disable iff (!rst_n)
      (fsel_reg[0] == FN_INCH_FORWARD && pin_sync[0] == act_level_reg[0]) |->
        !lvl_act[0];
  endproperty
  a_level_off: assert property (p_level_off)
    else $error("level function active on an inactive terminal");

  // Polarity: a set active-level bit makes a low pin the active one
  property p_invert;
    @(posedge clock) disable iff (!rst_n)
      (act_level_reg[1] && !pin_sync[1] && fsel_reg[1] == FN_INCH_FORWARD) |=>
        inch_forward;
  endproperty
  a_invert: assert property (p_invert)
    else $error("inverted low level not taken as active");

  property p_pos_trig;
    @(posedge clock) disable iff (!rst_n)
      (edg_act[2] && fsel_reg[2] == FN_POS_TRIGGER) |=> position_trigger;
  endproperty
  a_pos_trig: assert property (p_pos_trig)
    else $error("position trigger edge not passed on");

  property p_out_stable;
    @(posedge clock) disable iff (!rst_n)
      $stable(out_ctrl_reg) |=> $stable(output_terminal);
  endproperty
  a_out_stable: assert property (p_out_stable)
    else $error("output terminals moved without a control write");

  property p_fsel_write;
    @(posedge clock) disable iff (!rst_n)
      (reg_wr && reg_addr == ADDR_IN2_FSEL && wdata_legal) |=>
        (fsel_reg[1] == $past(reg_wdata[4:0]));
  endproperty
  a_fsel_write: assert property (p_fsel_write)
    else $error("legal function code not stored");

endmodule

// ==== rtl/tfm_pkg.sv ====
// Shared constants for the terminal function mapper.
// Assumes a single 40 MHz clock domain and a plain strobe register port.
package tfm_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [15:0] ADDR_IN1_FSEL     = 16'h0044;
  localparam logic [15:0] ADDR_IN2_FSEL     = 16'h0045;
  localparam logic [15:0] ADDR_IN3_FSEL     = 16'h0046;
  localparam logic [15:0] ADDR_IN4_FSEL     = 16'h0047;
  localparam logic [15:0] ADDR_OUT_CTRL     = 16'h0048;
  localparam logic [15:0] ADDR_ACT_LEVEL    = 16'h0049;
  localparam logic [15:0] ADDR_OUT0_FSEL    = 16'h004C;
  localparam logic [15:0] ADDR_STATUS       = 16'h0050;

  // ==========================================================
  // Widths and reset values
  localparam int          NUM_IN            = 4;
  localparam int          NUM_OUT           = 3;
  localparam int          NUM_GPIN          = 5;
  localparam logic [15:0] FSEL_RESET        = 16'h0000;
  localparam logic [15:0] WORD_ZERO         = 16'h0000;
  localparam logic [4:0]  FSEL_MAX          = 5'h14;

  // ==========================================================
  // Input function codes
  localparam logic [4:0]  FN_NONE           = 5'h00;
  localparam logic [4:0]  FN_MOTOR_ENABLE   = 5'h04;
  localparam logic [4:0]  FN_MOTOR_RELEASE  = 5'h05;
  localparam logic [4:0]  FN_POS_TRIGGER    = 5'h0A;
  localparam logic [4:0]  FN_LEVEL_ELEVEN   = 5'h0B;
  localparam logic [4:0]  FN_INCH_FORWARD   = 5'h0C;
  localparam logic [4:0]  FN_INCH_REVERSE   = 5'h0D;
  localparam logic [4:0]  FN_HOME_ENABLE    = 5'h0E;
  localparam logic [4:0]  FN_POSITION_TABLE = 5'h0F;
  localparam logic [4:0]  FN_GPIN_FIRST     = 5'h10;
  localparam logic [4:0]  FN_GPIN_LAST      = 5'h14;

  // Level-acting functions; all others except FN_NONE act on a change to the active level
  function automatic logic tfm_is_level_fn(input logic [4:0] code);
    tfm_is_level_fn = (code == FN_MOTOR_ENABLE) || (code == FN_MOTOR_RELEASE) ||
                      (code == FN_LEVEL_ELEVEN) || (code == FN_INCH_FORWARD) ||
                      (code == FN_INCH_REVERSE);
  endfunction

endpackage

// ==== rtl/tfm_sync2.sv ====
// Two-flop synchroniser for a bus of terminal pins.
// Assumes pins are asynchronous to clock; output is clean after two edges.
`timescale 1ns/1ps
module tfm_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_reg;

  // ==========================================================
  // Synchroniser; first stage feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      dout     <= '0;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule

// ==== test/tfm_mapper_tb.sv ====
// Self-checking bench for the terminal function mapper.
// Assumes the terminal model on the pins and a strobe register master here.
`timescale 1ns/1ps
module tfm_mapper_tb
  import tfm_pkg::*;
;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [3:0]  pin_level = 4'h0;
  logic [3:0]  input_terminal;
  logic [2:0]  output_terminal;
  logic        me, mr, inf, inr, hs, pt, ptr;
  logic [4:0]  gp;
  logic [11:0] obs;
  logic [15:0] d;
  int          failures = 0;
  int          n_checks = 0;

  // ==========================================================
  // Clock, instances
  always #12.5 clock = ~clock;
  assign obs = {gp, ptr, pt, hs, inr, inf, mr, me};

  tfm_terminal_model model (.clock(clock), .level(pin_level), .input_terminal(input_terminal));
  tfm_mapper DUT (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .input_terminal(input_terminal),
    .output_terminal(output_terminal), .motor_enable(me), .motor_release(mr),
    .inch_forward(inf), .inch_reverse(inr), .home_start(hs), .position_table(pt),
    .position_trigger(ptr), .general_input(gp));

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic end_sim;
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Observed output bit for each function code, -1 where none
  function automatic int exp_bit(input int code);
    case (code)
      4: exp_bit = 0;
      5: exp_bit = 1;
      12: exp_bit = 2;
      13: exp_bit = 3;
      14: exp_bit = 4;
      15: exp_bit = 5;
      10: exp_bit = 6;
      16, 17, 18, 19, 20: exp_bit = code - 9;
      default: exp_bit = -1;
    endcase
  endfunction

  // ==========================================================
  // Scenarios
  task automatic test_reset;
    for (int i = 0; i < 6; i++) begin
      rd(ADDR_IN1_FSEL + 16'(i), d);
      check("reset value", d, 16'h0000);
    end
    check("outputs at reset", {1'b0, output_terminal, obs}, 16'h0000);
    wr(ADDR_OUT0_FSEL, 16'h0008);
    rd(ADDR_OUT0_FSEL, d);
    check("output select storage", d, 16'h0008);
    wr(ADDR_IN1_FSEL, 16'h0015);
    rd(ADDR_IN1_FSEL, d);
    check("select above 20 kept out", d, 16'h0000);
  endtask

  // Every control word pattern reaches the three output terminals
  task automatic test_outputs;
    for (int v = 0; v < 8; v++) begin
      wr(ADDR_OUT_CTRL, 16'(v));
      repeat (2) @(posedge clock);
      #1 check("output terminals", {13'h0, output_terminal}, 16'(v));
    end
    wr(ADDR_OUT_CTRL, 16'h0000);
  endtask

  // Select a function, hold the pin active, count what each output does
  task automatic check_fn(input int t, input int code, input logic inv);
    int cnt[12];
    int e;
    logic lv;
    logic ok;
    e = exp_bit(code);
    lv = (code == 4 || code == 5 || code == 11 || code == 12 || code == 13);
    pin_level[t] <= inv;
    repeat (8) @(posedge clock);
    wr(ADDR_ACT_LEVEL, inv ? (16'h0001 << t) : 16'h0000);
    wr(ADDR_IN1_FSEL + 16'(t), 16'(code));
    rd(ADDR_IN1_FSEL + 16'(t), d);
    check("select readback", d, 16'(code));
    repeat (4) @(posedge clock);
    #1 check("idle outputs", {4'h0, obs}, 16'h0000);
    @(posedge clock);
    pin_level[t] <= ~inv;
    foreach (cnt[b]) cnt[b] = 0;
    repeat (12) begin
      @(posedge clock);
      #1 foreach (cnt[b]) if (obs[b] === 1'b1) cnt[b]++;
    end
    for (int b = 0; b < 12; b++) begin
      if (b != e) ok = (cnt[b] == 0);
      else if (lv) ok = (cnt[b] >= 6) && (obs[b] === 1'b1);
      else ok = (cnt[b] == 1);
      check($sformatf("code %0d out %0d", code, b), {15'h0, ok}, 16'h0001);
    end
    rd(ADDR_STATUS, d);
    check("pin status", d, {12'h000, pin_level});
    @(posedge clock);
    pin_level[t] <= inv;
    repeat (8) @(posedge clock);
    #1 check("released outputs", {4'h0, obs}, 16'h0000);
    wr(ADDR_IN1_FSEL + 16'(t), 16'h0000);
  endtask

  // Reset in mid-run clears registers and outputs at once, not at an edge
  task automatic test_midreset;
    pin_level[1] <= 1'b1;
    wr(ADDR_OUT_CTRL, 16'h0005);
    wr(ADDR_ACT_LEVEL, 16'h0000);
    wr(ADDR_IN2_FSEL, 16'(FN_INCH_FORWARD));
    repeat (4) @(posedge clock);
    #1 check("before reset", {1'b0, output_terminal, obs}, 16'h5004);
    @(posedge clock);
    rstn <= 1'b0;
    #1 check("outputs in reset", {1'b0, output_terminal, obs}, 16'h0000);
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    rd(ADDR_IN2_FSEL, d);
    check("select after reset", d, 16'h0000);
    rd(ADDR_OUT_CTRL, d);
    check("control after reset", d, 16'h0000);
    repeat (4) @(posedge clock);
    #1 check("outputs after reset", {1'b0, output_terminal, obs}, 16'h0000);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    test_reset();
    test_outputs();
    for (int c = 0; c <= 20; c++) check_fn(c % 4, c, 1'b0);
    check_fn(1, 12, 1'b1);
    check_fn(2, 14, 1'b1);
    check_fn(3, 18, 1'b1);
    test_midreset();
    rd(16'h0060, d);
    check("unmapped read", d, 16'h0000);
    end_sim();
  end

  // Whole run needs about 1150 cycles; this cuts a hang well past that
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end
endmodule

// ==== test/tfm_terminal_model.sv ====
// Model of the switches and sensors wired to the input terminals.
// Assumes the bench sets the wanted levels; pins move right after an edge.
`timescale 1ns/1ps
module tfm_terminal_model (
  input  wire logic       clock,
  input  wire logic [3:0] level,
  output logic      [3:0] input_terminal
);
  // ==========================================================
  // Pin drive
  // Contacts change just after an edge, so the design's synchroniser sees clean steps
  always_ff @(posedge clock) begin
    input_terminal <= level;
  end
endmodule
